// file: csw_pkg.sv
// Constants and types shared by the counter square-wave generator.
package csw_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int CSW_NUM_CH = 5;
  localparam int CSW_NUM_BASE = 5;
  localparam int CSW_CLK_HZ = 25_000_000;
  localparam int CSW_SRC_HZ = 1_000_000;
  localparam int CSW_PRE_DIV = CSW_CLK_HZ / CSW_SRC_HZ;
  localparam int CSW_DECADE = 10;
  localparam int CSW_BASE_SAMPLE_US = 1000;
  localparam int CSW_BASE_SAMPLE_CYC =
    CSW_BASE_SAMPLE_US * (CSW_CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int CSW_AW = 12;
  localparam int CSW_WIN_LSB = 7;
  localparam logic [11:0] CSW_DEF_BASE = 12'h300;
  localparam logic [6:0] CSW_OFF_CTRL = 7'h00;
  localparam logic [6:0] CSW_OFF_SAMPLE = 7'h04;
  localparam logic [6:0] CSW_OFF_STATUS = 7'h08;
  localparam logic [2:0] CSW_CH_FIRST = 3'h2;
  localparam logic [2:0] CSW_CH_LAST = 3'h6;
  localparam logic [1:0] CSW_SUB_CFG = 2'h0;
  localparam logic [1:0] CSW_SUB_RATE = 2'h1;
  localparam logic [1:0] CSW_SUB_DUTY = 2'h2;
  localparam logic [1:0] CSW_SUB_ARM = 2'h3;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CSW_CTRL_RUN_POS = 0;
  localparam int CSW_ST_ARMED_POS = 0;
  localparam int CSW_ST_OUT_POS = 8;
  localparam int CSW_ST_BASE_POS = 16;
  localparam int CSW_CFG_W = 7;
  localparam logic [6:0] CSW_RST_CFG = 7'h00;
  localparam logic [15:0] CSW_RST_RATE = 16'h0000;
  localparam logic [16:0] CSW_RST_DUTY = 17'h0_8000;
  localparam logic [15:0] CSW_RST_ARM = 16'h0000;
  localparam logic [7:0] CSW_RST_MULT = 8'h00;
  localparam logic [15:0] CSW_ARM_HALF = 16'h8000;
  localparam logic [16:0] CSW_DUTY_ONE = 17'h1_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {csw_mode_pwm, csw_mode_fm} csw_mode_t;
  typedef enum logic [2:0] {
    base_freq_sel_1mhz,
    base_freq_sel_100khz,
    base_freq_sel_10khz,
    base_freq_sel_1khz,
    base_freq_sel_100hz
  } csw_base_t;
  typedef struct packed {
    logic has_arm;
    logic idle_high;
    logic high_first;
    csw_base_t base_sel;
    csw_mode_t mode;
  } csw_cfg_t;
  typedef struct packed {
    logic [15:0] rate;
    logic [16:0] duty;
    logic [15:0] arm_val;
  } csw_chan_t;

endpackage : csw_pkg

// file: csw_timebase.sv
// Divider chain that makes the five base-frequency ticks.
`timescale 1ns/1ns
module csw_timebase
  import csw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  output logic [CSW_NUM_BASE-1:0] tick_q
);

  // ----------------------------------------------------------------
  // 1 MHz source from the system clock
  // ----------------------------------------------------------------
  logic [4:0] pre_q;
  logic src_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 5'h00;
      src_q <= 1'b0;
    end else begin
      src_q <= (pre_q == 5'(CSW_PRE_DIV - 1));
      if (pre_q == 5'(CSW_PRE_DIV - 1)) begin
        pre_q <= 5'h00;
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end
  assign tick_q[0] = src_q;

  // ----------------------------------------------------------------
  // Decade stages
  // ----------------------------------------------------------------
  for (genvar i = 1; i < CSW_NUM_BASE; i++) begin : g_dec
    logic [3:0] cnt_q;
    logic t_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 4'h0;
        t_q <= 1'b0;
      end else begin
        t_q <= tick_q[i-1] && (cnt_q == 4'(CSW_DECADE - 1));
        if (tick_q[i-1]) begin
          cnt_q <= (cnt_q == 4'(CSW_DECADE - 1)) ? 4'h0 : cnt_q + 4'h1;
        end
      end
    end
    assign tick_q[i] = t_q;
  end

endmodule : csw_timebase

// file: csw_channel.sv
// One counter channel: sampling, arming and waveform generation.
`timescale 1ns/1ns
module csw_channel
  import csw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CSW_NUM_BASE-1:0] tick,
  input wire logic sample_stb,
  input wire logic run,
  input wire csw_cfg_t cfg,
  input wire csw_chan_t set,
  output logic armed_q,
  output logic out_q
);

  logic [15:0] phase_q;
  logic [15:0] rate_q;
  logic [16:0] duty_q;
  logic armed_d;
  logic base_tick;
  logic level;

  // ----------------------------------------------------------------
  // Base selection, arming and level
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cfg.base_sel)
      base_freq_sel_1mhz: base_tick = tick[0];
      base_freq_sel_100khz: base_tick = tick[1];
      base_freq_sel_10khz: base_tick = tick[2];
      base_freq_sel_1khz: base_tick = tick[3];
      base_freq_sel_100hz: base_tick = tick[4];
      default: base_tick = tick[0];
    endcase
  end

  assign armed_d = run & (~cfg.has_arm | (set.arm_val >= CSW_ARM_HALF));
  // Duty always sizes the high part; low-first just mirrors it.
  assign level = cfg.high_first ? ({1'b0, phase_q} < duty_q)
                                : ({1'b0, phase_q} >= (CSW_DUTY_ONE - duty_q));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // Values are loaded while stopped so a run starts with settled inputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= CSW_RST_RATE;
      duty_q <= CSW_RST_DUTY;
    end else if (!run) begin
      rate_q <= set.rate;
      duty_q <= set.duty;
    end else if (sample_stb) begin
      if (cfg.mode == csw_mode_pwm) begin
        duty_q <= set.duty;
      end else begin
        rate_q <= set.rate;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 16'h0000;
    end else if (armed_d && !armed_q) begin
      phase_q <= 16'h0000;
    end else if (armed_q && base_tick) begin
      phase_q <= phase_q + rate_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= armed_q ? level : cfg.idle_high;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_arm_restart: assert property (
    armed_d && !armed_q |=> armed_q && phase_q == 16'h0000)
    else $error("phase not restarted on arming");
  a_high_first_start: assert property (
    $rose(armed_q) && cfg.high_first && duty_q != 17'h0_0000 |=> out_q)
    else $error("high-first period did not start high");
  a_low_first_start: assert property (
    $rose(armed_q) && !cfg.high_first && duty_q != CSW_DUTY_ONE |=> !out_q)
    else $error("low-first period did not start low");
  a_zero_duty_low: assert property (
    armed_q && duty_q == 17'h0_0000 |=> !out_q)
    else $error("zero duty produced a high part");
  a_phase_step: assert property (
    armed_q && armed_d && base_tick |=>
      phase_q == 16'($past(phase_q) + $past(rate_q)))
    else $error("phase did not advance by the rate");
  a_fm_duty_hold: assert property (
    run && cfg.mode == csw_mode_fm |=> $stable(duty_q))
    else $error("duty changed while running in frequency mode");
  a_sample_only: assert property (
    run && !sample_stb |=> $stable(duty_q) && $stable(rate_q))
    else $error("input taken outside a sample strobe");
  a_idle_level: assert property (
    !armed_q |=> out_q == $past(cfg.idle_high))
    else $error("disarmed output not at idle level");

endmodule : csw_channel

// file: csw_top.sv
// Top level of the counter square-wave generator with its APB slave.
`timescale 1ns/1ns
// Notes on behaviour
// - Each channel counts one of five bases: 1 MHz, 100 kHz, 10 kHz, 1 kHz, 100 Hz.
// - All bases come from one 1 MHz source; no 5 MHz source is used.
// - Pulse-width mode keeps the period fixed and takes the duty from 0 to 1.
// - Output frequency equals the selected base times the relative frequency.
// - High-first sequence starts each period with the high part.
// - Low-first sequence starts each period with the low part.
// - The duty value always sets the length of the high part.
// - A disarmed channel holds its output at a chosen static level.
// - Without an arm input a channel is armed exactly while running.
// - With an arm input a channel is armed at 0.5 or more and while running.
// - Frequency mode holds the duty constant while running.
// - Each channel drives its own output pin.
// - While running, inputs are taken once per sample period, a multiple of the base time.
// - Five independent channels, each set up on its own.
// - Accesses decode against a switch-set base address such as 0x300.
module csw_top
  import csw_pkg::*;
#(
  parameter int SAMPLE_CYC = CSW_BASE_SAMPLE_CYC
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CSW_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [CSW_AW-1:0] base_sw,
  output logic [CSW_NUM_CH-1:0] ch_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic run_q;
  logic [7:0] mult_q;
  csw_cfg_t cfg_q [CSW_NUM_CH];
  csw_chan_t chan_q [CSW_NUM_CH];
  logic [CSW_AW-1:0] sw1_q;
  logic [CSW_AW-1:0] sw2_q;
  logic [CSW_AW-1:0] sw3_q;
  logic [CSW_AW-1:0] base_q;
  logic [31:0] bs_cnt_q;
  logic [7:0] mult_cnt_q;
  logic sample_stb_q;
  logic [CSW_NUM_BASE-1:0] tick;
  logic [CSW_NUM_CH-1:0] ch_armed;
  logic acc;
  logic answer;
  logic done;
  logic hit;
  logic ch_hit;
  logic wr_ok;
  logic valid_d;
  logic [31:0] rdata_d;
  logic [6:0] off;
  logic [2:0] ch_sel;

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Base address switches
  // ----------------------------------------------------------------
  // Switches are static in use; three stages still keep a moving
  // switch from feeding a half-settled address into the decode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw1_q <= CSW_DEF_BASE;
      sw2_q <= CSW_DEF_BASE;
      sw3_q <= CSW_DEF_BASE;
    end else begin
      sw1_q <= base_sw;
      sw2_q <= sw1_q;
      sw3_q <= sw2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= CSW_DEF_BASE;
    end else if (sw2_q == sw3_q) begin
      base_q <= sw3_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign acc = psel & penable;
  assign answer = acc & ~pready_q;
  assign done = acc & pready_q;
  assign off = paddr[6:0];
  assign hit = (paddr[CSW_AW-1:CSW_WIN_LSB] == base_q[CSW_AW-1:CSW_WIN_LSB]);
  assign ch_hit = (off[6:4] >= CSW_CH_FIRST) && (off[6:4] <= CSW_CH_LAST);
  assign ch_sel = off[6:4] - CSW_CH_FIRST;
  assign wr_ok = done & pwrite & valid_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    valid_d = 1'b0;
    if (hit && paddr[1:0] == 2'b00) begin
      if (ch_hit) begin
        valid_d = 1'b1;
        unique case (off[3:2])
          CSW_SUB_CFG: begin
            rdata_d[CSW_CFG_W-1:0] = cfg_q[ch_sel];
          end
          CSW_SUB_RATE: begin
            rdata_d[15:0] = chan_q[ch_sel].rate;
          end
          CSW_SUB_DUTY: begin
            rdata_d[16:0] = chan_q[ch_sel].duty;
          end
          CSW_SUB_ARM: begin
            rdata_d[15:0] = chan_q[ch_sel].arm_val;
          end
        endcase
      end else begin
        unique case (off)
          CSW_OFF_CTRL: begin
            valid_d = 1'b1;
            rdata_d[CSW_CTRL_RUN_POS] = run_q;
          end
          CSW_OFF_SAMPLE: begin
            valid_d = 1'b1;
            rdata_d[7:0] = mult_q;
          end
          CSW_OFF_STATUS: begin
            valid_d = 1'b1;
            rdata_d[CSW_ST_ARMED_POS +: CSW_NUM_CH] = ch_armed;
            rdata_d[CSW_ST_OUT_POS +: CSW_NUM_CH] = ch_out;
            rdata_d[CSW_ST_BASE_POS +: CSW_AW] = base_q;
          end
          default: begin
            valid_d = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One wait state on every access keeps prdata a plain flop output.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= answer;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (answer) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= answer & ~valid_d;
    end
  end

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
    end else if (wr_ok && !ch_hit && off == CSW_OFF_CTRL) begin
      run_q <= pwdata[CSW_CTRL_RUN_POS];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_q <= CSW_RST_MULT;
    end else if (wr_ok && !ch_hit && off == CSW_OFF_SAMPLE) begin
      mult_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Sample period
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bs_cnt_q <= 32'h0000_0000;
    end else if (bs_cnt_q >= 32'(SAMPLE_CYC - 1)) begin
      bs_cnt_q <= 32'h0000_0000;
    end else begin
      bs_cnt_q <= bs_cnt_q + 32'h0000_0001;
    end
  end

  // The sample period is (mult + 1) base sample times.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_cnt_q <= 8'h00;
      sample_stb_q <= 1'b0;
    end else begin
      sample_stb_q <= 1'b0;
      if (bs_cnt_q >= 32'(SAMPLE_CYC - 1)) begin
        if (mult_cnt_q >= mult_q) begin
          mult_cnt_q <= 8'h00;
          sample_stb_q <= 1'b1;
        end else begin
          mult_cnt_q <= mult_cnt_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase and channels
  // ----------------------------------------------------------------
  csw_timebase u_tb (
    .clk(clk),
    .rst_n(rst_n),
    .tick_q(tick)
  );

  for (genvar i = 0; i < CSW_NUM_CH; i++) begin : g_ch
    logic we;
    assign we = wr_ok && ch_hit && ch_sel == 3'(i);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q[i] <= csw_cfg_t'(CSW_RST_CFG);
        chan_q[i].rate <= CSW_RST_RATE;
        chan_q[i].duty <= CSW_RST_DUTY;
        chan_q[i].arm_val <= CSW_RST_ARM;
      end else if (we) begin
        unique case (off[3:2])
          CSW_SUB_CFG: begin
            cfg_q[i] <= csw_cfg_t'(pwdata[CSW_CFG_W-1:0]);
          end
          CSW_SUB_RATE: begin
            chan_q[i].rate <= pwdata[15:0];
          end
          CSW_SUB_DUTY: begin
            chan_q[i].duty <= pwdata[16:0];
          end
          CSW_SUB_ARM: begin
            chan_q[i].arm_val <= pwdata[15:0];
          end
        endcase
      end
    end

    csw_channel u_ch (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .sample_stb(sample_stb_q),
      .run(run_q),
      .cfg(cfg_q[i]),
      .set(chan_q[i]),
      .armed_q(ch_armed[i]),
      .out_q(ch_out[i])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] gap_q;
  logic gap_seen_q;
  logic [3:0] dec_q;
  logic dec_seen_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 8'h00;
      gap_seen_q <= 1'b0;
    end else if (tick[0]) begin
      gap_q <= 8'h00;
      gap_seen_q <= 1'b1;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_q <= 4'h0;
      dec_seen_q <= 1'b0;
    end else if (tick[1]) begin
      dec_q <= 4'h0;
      dec_seen_q <= 1'b1;
    end else if (tick[0]) begin
      dec_q <= dec_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_src_gap: assert property (
    tick[0] && gap_seen_q |-> gap_q == 8'(CSW_PRE_DIV - 1))
    else $error("1 MHz tick spacing wrong");
  a_decade_count: assert property (
    tick[1] && dec_seen_q |-> dec_q == 4'(CSW_DECADE))
    else $error("decade stage did not divide by ten");
  a_decade_follow: assert property (
    tick[2] |-> $past(tick[1]))
    else $error("decade tick without its source tick");
  a_stop_disarm: assert property (
    !run_q |=> ch_armed == '0)
    else $error("channel armed while stopped");
  a_run_arm: assert property (
    run_q && !cfg_q[0].has_arm |=> ch_armed[0])
    else $error("channel without arm input not armed");
  a_arm_low: assert property (
    cfg_q[4].has_arm && chan_q[4].arm_val < CSW_ARM_HALF |=> !ch_armed[4])
    else $error("arm value below half armed the channel");
  a_arm_high: assert property (
    run_q && cfg_q[4].has_arm && chan_q[4].arm_val >= CSW_ARM_HALF
      |=> ch_armed[4])
    else $error("arm value at half or more did not arm");
  a_decode_miss: assert property (
    answer && !hit |=> pready_q && pslverr_q)
    else $error("access outside the base window not refused");
  a_ready_pulse: assert property (
    pready_q |=> !pready_q)
    else $error("pready held for more than one cycle");

  c_arm_rise: cover property ($rose(ch_armed[0]));
  c_sample: cover property (run_q && sample_stb_q);
  c_fm_run: cover property (ch_armed[1] && cfg_q[1].mode == csw_mode_fm);
  c_bus_err: cover property (pready_q && pslverr_q);

endmodule : csw_top

// file: csw_load.sv
// TTL load model that counts rising edges and high time on each pin.
`timescale 1ns/1ns
module csw_load
  import csw_pkg::*;
(
  input wire logic clk,
  input wire logic clr,
  input wire logic [CSW_NUM_CH-1:0] ch_out,
  output int rises[CSW_NUM_CH],
  output int highs[CSW_NUM_CH]
);
  logic [CSW_NUM_CH-1:0] last_q;
  // A TTL input only loads its own pin and never drives it back.
  always_ff @(posedge clk) begin
    last_q <= ch_out;
    for (int i = 0; i < CSW_NUM_CH; i++) begin
      rises[i] <= clr ? 0 : rises[i] + int'(ch_out[i] & ~last_q[i]);
      highs[i] <= clr ? 0 : highs[i] + int'(ch_out[i]);
    end
  end
endmodule : csw_load

// file: counter_square_wave_generator_tb.sv
// Self-checking testbench for the counter square-wave generator.
`timescale 1ns/1ns
module counter_square_wave_generator_tb;
  import csw_pkg::*;
  localparam int W = 40000;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, clr = 1;
  logic [11:0] paddr = '0, base_sw = 12'h300, base = 12'h300;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err;
  logic [4:0] ch_out, hf;
  int rises[5], highs[5], rate[5], duty[5];
  int num_errors = 0, total_checks = 0;
  longint tk;
  always #20 clk = ~clk;
  csw_top #(.SAMPLE_CYC(20)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .base_sw(base_sw),
    .ch_out(ch_out));
  csw_load i_load (.clk(clk), .clr(clr), .ch_out(ch_out), .rises(rises),
    .highs(highs));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  task automatic near(input int got, exp, tol, input string m);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      num_errors++;
      $display("Error at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : near
  // Read data and error are taken at the edge that samples pready high.
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic logic [11:0] cha(int c, int s);
    return base + 12'(32 + 16 * c + 4 * s);
  endfunction : cha
  task automatic complete_run();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(78985));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    apb(0, cha(3, 2), 0);
    check(rd, 32'h0000_8000, "duty reset");
    apb(0, base + 12'h008, 0);
    check(32'(rd[27:16]), 32'h0000_0300, "base field");
    apb(1, base + 12'h014, 5);
    check(32'(err), 32'h0000_0001, "unmapped");
    apb(0, 12'h000, 0);
    check(32'(err), 32'h0000_0001, "outside base");
    apb(1, base + 12'h004, 3);
    apb(0, base + 12'h004, 0);
    check(rd, 32'h0000_0003, "sample mult");
    $display("Test map done");
    for (int c = 0; c < 5; c++) begin
      hf[c] = 1'($urandom_range(0, 1));
      rate[c] = $urandom_range(32'h1000, 32'h3fff);
      duty[c] = $urandom_range(32'h8000, 32'hc000);
      apb(1, cha(c, 0), {25'h0, 1'b0, ~hf[c], hf[c], 3'(c), c == 1});
      apb(1, cha(c, 1), rate[c]);
      apb(1, cha(c, 2), duty[c]);
    end
    check(32'(ch_out), {27'h0, ~hf}, "idle levels");
    apb(1, base, 1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(32'(ch_out), 32'(hf), "first level");
    clr <= 0;
    repeat (W) @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      tk = 25 * 10 ** c;
      near(rises[c], int'(rate[c] * W / (65536 * tk)), 1, "rises");
      near(highs[c], int'(longint'(duty[c]) * W / 65536),
        int'(65536 * tk / rate[c] + tk), "highs");
    end
    apb(0, base + 12'h008, 0);
    check(32'(rd[4:0]), 32'h0000_001f, "armed running");
    $display("Test waveform done");
    apb(1, cha(0, 2), 32'h0001_0000);
    apb(1, cha(1, 2), 32'h0001_0000);
    clr <= 1;
    repeat (200) @(posedge clk);
    clr <= 0;
    repeat (8000) @(posedge clk);
    @(negedge clk);
    check(32'(highs[0]), 32'(8000), "duty one");
    check(32'(highs[1] < 8000), 32'h0000_0001, "fm duty held");
    $display("Test sampling done");
    apb(1, cha(4, 0), 32'h0000_0048);
    foreach (rate[i]) if (i < 2) begin
      apb(1, cha(4, 3), 32'h7fff + i);
      apb(0, base + 12'h008, 0);
      check(32'(rd[4]), 32'(i), "arm threshold");
    end
    apb(1, base, 0);
    apb(0, base + 12'h008, 0);
    check(32'(rd[4:0]), 32'h0000_0000, "stopped");
    $display("Test arming done");
    base_sw <= {5'($urandom_range(0, 31)) ^ 5'h06 | 5'h01, 7'h00};
    repeat (8) @(posedge clk);
    base = base_sw;
    apb(0, base + 12'h008, 0);
    check(32'(rd[27:16]), 32'(base), "moved base");
    apb(0, 12'h308, 0);
    check(32'(err), 32'(base != 12'h300), "old base");
    $display("Test base switch done");
    complete_run();
  end
endmodule : counter_square_wave_generator_tb
